// File: rtl/psr_defines.svh
// Register offsets, field positions, reset values and host register map
`ifndef PSR_DEFINES_SVH
`define PSR_DEFINES_SVH

// Device register offsets on the link
`define PSR_ADDR_LPCONF 8'h1a
`define PSR_ADDR_INTSRC 8'h25
`define PSR_ADDR_QSTAT 8'h26
`define PSR_ADDR_DSTAT 8'h27
`define PSR_ADDR_PRESS_L 8'h28
`define PSR_ADDR_PRESS_M 8'h29
`define PSR_ADDR_PRESS_H 8'h2a
`define PSR_ADDR_TEMP_L 8'h2b
`define PSR_ADDR_TEMP_H 8'h2c
`define PSR_ADDR_FLT_RST 8'h33

// Field positions
`define PSR_LPCONF_LC_BIT 0
`define PSR_LPCONF_RSVD_BIT 1
`define PSR_LPCONF_RESET 8'h00
`define PSR_INTSRC_BOOT_BIT 7
`define PSR_DSTAT_TOR_BIT 5
`define PSR_DSTAT_POR_BIT 4
`define PSR_DSTAT_TDA_BIT 1
`define PSR_DSTAT_PDA_BIT 0
`define PSR_QUEUE_FULL 6'h20

// Host register map on APB
`define PSR_APB_CMD 12'h000
`define PSR_APB_STAT 12'h004
`define PSR_CMD_WDATA_LSB 8
`define PSR_CMD_WRITE_BIT 16
`define PSR_STAT_BUSY_BIT 0
`define PSR_STAT_REFUSED_BIT 1
`define PSR_STAT_RDATA_LSB 8

`endif

// File: rtl/psr_pkg.sv
// Types shared by the sensor status readout ends
package psr_pkg;
  typedef logic [7:0] psr_byte_t;
  typedef enum logic [2:0] {
    PSR_IDLE,
    PSR_RMW_READ,
    PSR_RMW_WAIT,
    PSR_ISSUE,
    PSR_WAIT
  } psr_host_state_e;
endpackage

// File: rtl/psr_link_if.sv
// Register link between the sensor readout and its host controller
`timescale 1ns/1ps
interface psr_link_if;
  psr_pkg::psr_byte_t addr;
  psr_pkg::psr_byte_t wdata;
  logic wr;
  logic rd;
  psr_pkg::psr_byte_t rdata;
  logic rvalid;
  modport device (input addr, input wdata, input wr, input rd, output rdata, output rvalid);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input rvalid);
endinterface

// File: rtl/psr_flag.sv
// Sticky status flag where a set wins over a clear in the same cycle
`timescale 1ns/1ps
module psr_flag (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  // Set has priority so an event at the clear edge is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end
endmodule

// File: rtl/psr_device.sv
// Sensor end: status flags, result registers and filter reset on the register link
//
// Chosen here: the register link device port; the APB slave sits in the host end.
`timescale 1ns/1ps
`include "psr_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// (R1) Host writes zero to six upper bits
// (R2) Host preserves reserved bit on writes
// (R3) Low-current bit resets zero, one selects
// (R4) Host changes low-current only when powered down
// (R5) Low-current applies to single-shot and continuous
// (R6) Bit 7 shows trimming reload, 6..3 zero
// (R7) Interrupt-active set when any event occurred
// (R8) Separate low and high pressure event flags
// (R9) Watermark flag when fill reaches threshold
// (R10) Overrun flag when full and overwritten
// (R11) Six-bit fill level, 32 means full
// (R12) Overrun flags when unread result overwritten
// (R13) Available flags set on new result
// (R14) Data status refreshed once per rate cycle
// (R15) 24-bit pressure at 28h, 29h, 2Ah
// (R16) Pressure equals measured minus offset
// (R17) 16-bit temperature at 2Bh and 2Ch
// (R18) Reading 33h resets active lowpass filter
// (R19) Offset is 16-bit two's complement pair
// (R20) Single-shot completion clears trigger, updates results
// (R21) Reading result high byte clears available
// (R22) Multi-byte results read coherently via snapshot
module psr_device #(
  parameter int FILL_W = 6,
  parameter int WTM_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  psr_link_if.device link,
  input wire logic boot_active,
  input wire logic diff_low_event,
  input wire logic diff_high_event,
  input wire logic [FILL_W-1:0] queue_fill_level,
  input wire logic [WTM_W-1:0] watermark_level,
  input wire logic queue_overrun_bit,
  input wire logic rate_tick,
  input wire logic oneshot_done,
  input wire logic press_new,
  input wire logic [23:0] press_measured,
  input wire logic temp_new,
  input wire logic [15:0] temp_measured,
  input wire logic [15:0] press_offset,
  input wire logic press_lowpass_filter,
  output logic low_current_select,
  output logic oneshot_clear,
  output logic filter_reset
);

  ////////////////////////////////////////////////////////////////////////////////
  // Link decode
  logic rd_press_l;
  logic rd_press_h;
  logic rd_temp_l;
  logic rd_temp_h;
  logic commit;
  logic [7:0] lpconf;
  logic [1:0] pending;
  logic [1:0] new_in;
  logic [1:0] rd_high;
  logic [1:0] avail;
  logic [1:0] queue_overrun_flag;
  logic [23:0] stage [2];
  logic [23:0] value_in [2];
  logic [23:0] result [2];
  logic [23:0] press_snap;
  logic [15:0] temp_snap;
  logic [23:0] press_offset_ext;
  logic [7:0] int_src;
  logic [7:0] queue_stat;
  logic [7:0] data_stat;
  logic [7:0] next_rdata;
  logic evt_low;
  logic evt_high;

  assign rd_press_l = link.rd && (link.addr == `PSR_ADDR_PRESS_L);
  assign rd_press_h = link.rd && (link.addr == `PSR_ADDR_PRESS_H);
  assign rd_temp_l = link.rd && (link.addr == `PSR_ADDR_TEMP_L);
  assign rd_temp_h = link.rd && (link.addr == `PSR_ADDR_TEMP_H);

  ////////////////////////////////////////////////////////////////////////////////
  // Low-power configuration
  // All eight bits are stored; the host keeps the top bits zero and bit 1 intact
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lpconf <= `PSR_LPCONF_RESET; // [R3]
    end else if (link.wr && link.addr == `PSR_ADDR_LPCONF) begin
      lpconf <= link.wdata;
    end
  end

  // One level drives the whole conversion chain, single-shot and continuous alike
  assign low_current_select = lpconf[`PSR_LPCONF_LC_BIT]; // [R3] [R5]

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion results
  // Offset sign-extended to the pressure width before subtraction
  assign press_offset_ext = {{8{press_offset[15]}}, press_offset}; // [R19]
  assign value_in[0] = press_measured - press_offset_ext; // [R16]
  assign value_in[1] = {{8{temp_measured[15]}}, temp_measured};
  assign new_in = {temp_new, press_new};
  assign rd_high = {rd_temp_h, rd_press_h};

  // Results land only at a rate boundary or at single-shot completion
  assign commit = rate_tick || oneshot_done; // [R14] [R20]

  // Index 0 is pressure, index 1 is temperature
  for (genvar i = 0; i < 2; i++) begin : g_qty
    // Staging holds the newest sample until the next commit point
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stage[i] <= 24'h000000;
        pending[i] <= 1'b0;
      end else if (new_in[i]) begin
        stage[i] <= value_in[i];
        pending[i] <= 1'b1;
      end else if (commit) begin
        pending[i] <= 1'b0;
      end
    end

    // A sample arriving in the commit cycle itself waits for the next one
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        result[i] <= 24'h000000;
      end else if (commit && pending[i]) begin
        result[i] <= stage[i]; // [R15] [R17] [R20]
      end
    end

    psr_flag u_avail (
      .pclk(pclk),
      .presetn(presetn),
      .set(commit && pending[i]), // [R13]
      .clr(rd_high[i]), // [R21]
      .q(avail[i])
    );

    // Overwriting a result nobody has taken yet marks an overrun
    psr_flag u_ovr (
      .pclk(pclk),
      .presetn(presetn),
      .set(commit && pending[i] && avail[i]), // [R12]
      .clr(rd_high[i]),
      .q(queue_overrun_flag[i])
    );
  end

  // Single-shot trigger self-clears on completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oneshot_clear <= 1'b0;
    end else begin
      oneshot_clear <= oneshot_done; // [R20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Coherent snapshots
  // Low-byte read freezes the upper bytes so a later commit cannot mix samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      press_snap <= 24'h000000;
    end else if (rd_press_l) begin
      press_snap <= result[0]; // [R22]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_snap <= 16'h0000;
    end else if (rd_temp_l) begin
      temp_snap <= result[1][15:0]; // [R22]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event flags
  // Pressure events are held until the host reads the interrupt source
  psr_flag u_evt_low (
    .pclk(pclk),
    .presetn(presetn),
    .set(diff_low_event), // [R8]
    .clr(link.rd && link.addr == `PSR_ADDR_INTSRC),
    .q(evt_low)
  );

  psr_flag u_evt_high (
    .pclk(pclk),
    .presetn(presetn),
    .set(diff_high_event), // [R8]
    .clr(link.rd && link.addr == `PSR_ADDR_INTSRC),
    .q(evt_high)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Status bytes
  always_comb begin
    int_src = 8'h00; // [R6]
    int_src[`PSR_INTSRC_BOOT_BIT] = boot_active; // [R6]
    int_src[2] = evt_low || evt_high; // [R7]
    int_src[1] = evt_low; // [R8]
    int_src[0] = evt_high; // [R8]
  end

  // Watermark compares the live fill against the programmed level
  always_comb begin
    queue_stat = 8'h00;
    queue_stat[7] = (queue_fill_level >= FILL_W'(watermark_level)); // [R9]
    queue_stat[6] = queue_overrun_bit && (queue_fill_level == `PSR_QUEUE_FULL); // [R10]
    queue_stat[5:0] = queue_fill_level; // [R11]
  end

  always_comb begin
    data_stat = 8'h00;
    data_stat[`PSR_DSTAT_TOR_BIT] = queue_overrun_flag[1]; // [R12]
    data_stat[`PSR_DSTAT_POR_BIT] = queue_overrun_flag[0]; // [R12]
    data_stat[`PSR_DSTAT_TDA_BIT] = avail[1]; // [R13]
    data_stat[`PSR_DSTAT_PDA_BIT] = avail[0]; // [R13]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read zero
  always_comb begin
    case (link.addr)
      `PSR_ADDR_LPCONF: next_rdata = lpconf;
      `PSR_ADDR_INTSRC: next_rdata = int_src;
      `PSR_ADDR_QSTAT: next_rdata = queue_stat;
      `PSR_ADDR_DSTAT: next_rdata = data_stat;
      `PSR_ADDR_PRESS_L: next_rdata = result[0][7:0]; // [R15]
      `PSR_ADDR_PRESS_M: next_rdata = press_snap[15:8]; // [R15]
      `PSR_ADDR_PRESS_H: next_rdata = press_snap[23:16]; // [R15]
      `PSR_ADDR_TEMP_L: next_rdata = result[1][7:0]; // [R17]
      `PSR_ADDR_TEMP_H: next_rdata = temp_snap[15:8]; // [R17]
      default: next_rdata = 8'h00;
    endcase
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.rdata <= 8'h00;
      link.rvalid <= 1'b0;
    end else begin
      link.rvalid <= link.rd;
      if (link.rd) begin
        link.rdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Filter reset on read; ignored while the filter is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_reset <= 1'b0;
    end else begin
      filter_reset <= link.rd && (link.addr == `PSR_ADDR_FLT_RST) && press_lowpass_filter; // [R18]
    end
  end

endmodule

// File: rtl/psr_host.sv
// Host end: APB command registers driving the sensor register link
`timescale 1ns/1ps
`include "psr_defines.svh"

module psr_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic device_powered_down,
  psr_link_if.host link
);

  psr_pkg::psr_host_state_e state;
  logic cmd_write;
  logic refused;
  logic [7:0] last_rdata;
  logic apb_wr;
  logic start;
  logic lc_change;

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: always ready, never errors
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign apb_wr = psel && penable && pwrite;
  // Commands while busy are dropped rather than queued
  assign start = apb_wr && (paddr == `PSR_APB_CMD) && (state == psr_pkg::PSR_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      if (paddr == `PSR_APB_STAT) begin
        prdata[`PSR_STAT_BUSY_BIT] <= (state != psr_pkg::PSR_IDLE);
        prdata[`PSR_STAT_REFUSED_BIT] <= refused;
        prdata[`PSR_STAT_RDATA_LSB +: 8] <= last_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link strobes come straight from the state
  assign link.rd = (state == psr_pkg::PSR_RMW_READ) || (state == psr_pkg::PSR_ISSUE && !cmd_write);
  assign link.wr = (state == psr_pkg::PSR_ISSUE) && cmd_write;
  assign lc_change = link.wdata[`PSR_LPCONF_LC_BIT] != link.rdata[`PSR_LPCONF_LC_BIT];

  // Sequencer; configuration writes go through read-modify-write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= psr_pkg::PSR_IDLE;
      link.addr <= 8'h00;
      link.wdata <= 8'h00;
      cmd_write <= 1'b0;
      refused <= 1'b0;
      last_rdata <= 8'h00;
    end else begin
      case (state)
        psr_pkg::PSR_IDLE: begin
          if (start) begin
            link.addr <= pwdata[7:0];
            link.wdata <= pwdata[`PSR_CMD_WDATA_LSB +: 8];
            cmd_write <= pwdata[`PSR_CMD_WRITE_BIT];
            refused <= 1'b0;
            if (pwdata[`PSR_CMD_WRITE_BIT] && pwdata[7:0] == `PSR_ADDR_LPCONF) begin
              state <= psr_pkg::PSR_RMW_READ; // [R2]
            end else begin
              state <= psr_pkg::PSR_ISSUE; // [R18]
            end
          end
        end
        psr_pkg::PSR_RMW_READ: begin
          state <= psr_pkg::PSR_RMW_WAIT;
        end
        psr_pkg::PSR_RMW_WAIT: begin
          if (link.rvalid) begin
            if (lc_change && !device_powered_down) begin
              refused <= 1'b1; // [R4]
              state <= psr_pkg::PSR_IDLE;
            end else begin
              // Top six bits forced low, reserved bit copied back
              link.wdata <= {6'h00, link.rdata[`PSR_LPCONF_RSVD_BIT],
                             link.wdata[`PSR_LPCONF_LC_BIT]}; // [R1] [R2]
              state <= psr_pkg::PSR_ISSUE;
            end
          end
        end
        psr_pkg::PSR_ISSUE: begin
          state <= cmd_write ? psr_pkg::PSR_IDLE : psr_pkg::PSR_WAIT;
        end
        psr_pkg::PSR_WAIT: begin
          if (link.rvalid) begin
            last_rdata <= link.rdata;
            state <= psr_pkg::PSR_IDLE;
          end
        end
        default: begin
          state <= psr_pkg::PSR_IDLE;
        end
      endcase
    end
  end

endmodule

// File: tb/psr_link_checker.sv
// Concurrent checks on the register link between host and sensor ends
`timescale 1ns/1ps
module psr_link_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire psr_pkg::psr_byte_t addr,
  input wire psr_pkg::psr_byte_t wdata,
  input wire logic wr,
  input wire logic rd,
  input wire psr_pkg::psr_byte_t rdata,
  input wire logic rvalid,
  input wire logic device_powered_down,
  input wire logic press_lowpass_filter,
  input wire logic filter_reset,
  input wire logic low_current_select
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // Link timing: one answer per read, exactly one cycle later
  a_read_answer: assert property (rd |=> rvalid) else $error("read not answered");
  a_valid_cause: assert property (rvalid |-> $past(rd)) else $error("answer without read");
  // Filter reset only from a read of its trigger while the filter runs
  a_filter_pulse: assert property (rd && addr == 8'h33 && press_lowpass_filter |=> filter_reset)
    else $error("filter reset missing");
  a_filter_cause: assert property (filter_reset |-> $past(rd && addr == 8'h33 && press_lowpass_filter))
    else $error("filter reset without cause");
  // Unused source bits read zero, summary bit is the or of the events
  a_intsrc_bits: assert property (rvalid && $past(addr) == 8'h25 |->
    rdata[6:3] == 4'h0 && rdata[2] == (rdata[1] | rdata[0])) else $error("source bits wrong");
  // Low-current bit follows accepted writes and nothing else
  a_lc_follow: assert property (wr && addr == 8'h1a |=> low_current_select == $past(wdata[0]))
    else $error("low current not taken");
  a_lc_hold: assert property (!(wr && addr == 8'h1a) |=> $stable(low_current_select))
    else $error("low current changed");
  // Host side: upper bits zero, reserved bit carried over from a read just before
  a_upper_zero: assert property (wr && addr == 8'h1a |-> wdata[7:2] == 6'h00)
    else $error("upper config bits set");
  a_rmw_order: assert property (wr && addr == 8'h1a |-> $past(rvalid) && wdata[1] == $past(rdata[1]))
    else $error("reserved bit not preserved");
  a_lc_refuse: assert property (wr && addr == 8'h1a && !device_powered_down |->
    wdata[0] == low_current_select) else $error("low current changed while running");
endmodule

// File: tb/test_pressure_sensor_status_readout.sv
// Self-checking bench: APB host end driving the sensor end over the link
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module test_pressure_sensor_status_readout;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, device_powered_down;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic boot_active, diff_low_event, diff_high_event, queue_overrun_bit, rate_tick;
  logic oneshot_done, press_new, temp_new, press_lowpass_filter;
  logic low_current_select, oneshot_clear, filter_reset;
  logic [5:0] queue_fill_level;
  logic [4:0] watermark_level;
  logic [23:0] press_measured, p, e;
  logic [15:0] temp_measured, press_offset, t;
  logic [7:0] q[$];
  logic [7:0] x;
  int failures, total_checks, cyc;
  psr_link_if link_bus();
  psr_device psr_device_inst (.pclk(pclk), .presetn(presetn), .link(link_bus),
    .boot_active(boot_active), .diff_low_event(diff_low_event),
    .diff_high_event(diff_high_event), .queue_fill_level(queue_fill_level),
    .watermark_level(watermark_level), .queue_overrun_bit(queue_overrun_bit),
    .rate_tick(rate_tick), .oneshot_done(oneshot_done), .press_new(press_new),
    .press_measured(press_measured), .temp_new(temp_new), .temp_measured(temp_measured),
    .press_offset(press_offset), .press_lowpass_filter(press_lowpass_filter),
    .low_current_select(low_current_select), .oneshot_clear(oneshot_clear),
    .filter_reset(filter_reset));
  psr_host psr_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .device_powered_down(device_powered_down), .link(link_bus));
  psr_link_checker psr_link_checker_inst (.pclk(pclk), .presetn(presetn),
    .addr(link_bus.addr), .wdata(link_bus.wdata), .wr(link_bus.wr), .rd(link_bus.rd),
    .rdata(link_bus.rdata), .rvalid(link_bus.rvalid),
    .device_powered_down(device_powered_down), .press_lowpass_filter(press_lowpass_filter),
    .filter_reset(filter_reset), .low_current_select(low_current_select));

  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Hang guard, far above the several hundred cycles the sequence needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      test_done;
    end
  end
  // Link answers checked off mid-cycle, clear of the edge that launches them
  always @(negedge pclk) begin
    if (link_bus.rvalid === 1'b1) begin
      x = q.pop_front();
      `CHK("link rdata", x, link_bus.rdata)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Device access through the command register; polls busy so no command is lost
  task automatic dev(input logic [7:0] a, input logic [7:0] d, input logic w,
                     input logic [7:0] ex);
    logic exp_ref;
    if (!w || a == 8'h1a) q.push_back(ex);
    apb(1'b1, 12'h000, {15'h0, w, d, a});
    do begin
      @(posedge pclk);
      apb(1'b0, 12'h004, 32'h0);
      @(negedge pclk);
    end while (prdata[0] !== 1'b0);
    // Final status poll carries the refusal and the last byte read
    exp_ref = w && a == 8'h1a && !device_powered_down && d[0] != ex[0];
    `CHK("stat refused", exp_ref, prdata[1])
    if (!w) `CHK("stat rdata", ex, prdata[15:8])
    @(posedge pclk);
  endtask
  // Stage one sample of each quantity, then commit on a rate tick or single-shot end
  task automatic stage(input logic [23:0] sp, input logic [15:0] st, input logic os);
    press_measured <= sp; temp_measured <= st; press_new <= 1'b1; temp_new <= 1'b1;
    @(posedge pclk);
    press_new <= 1'b0; temp_new <= 1'b0; rate_tick <= !os; oneshot_done <= os;
    @(posedge pclk);
    rate_tick <= 1'b0; oneshot_done <= 1'b0;
    // Trigger clear stands only in the cycle after completion
    @(negedge pclk);
    `CHK("oneshot_clear", os, oneshot_clear)
    @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'h6831;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
    pwdata = 32'h0; device_powered_down = 1'b1; boot_active = 1'b0; diff_low_event = 1'b0;
    diff_high_event = 1'b0; queue_fill_level = 6'h0; watermark_level = 5'h0;
    queue_overrun_bit = 1'b0; rate_tick = 1'b0; oneshot_done = 1'b0; press_new = 1'b0;
    temp_new = 1'b0; press_measured = 24'h0; temp_measured = 16'h0; press_offset = 16'h0;
    press_lowpass_filter = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    dev(8'h1a, 8'h00, 1'b0, 8'h00);
    dev(8'h27, 8'h00, 1'b0, 8'h00);
    dev(8'h40, 8'h00, 1'b0, 8'h00);
    // Low-current select: set while powered down, refused while running
    dev(8'h1a, 8'hfd, 1'b1, 8'h00);
    `CHK("low_current_select", 1'b1, low_current_select)
    device_powered_down <= 1'b0;
    dev(8'h1a, 8'h00, 1'b1, 8'h01);
    `CHK("low_current_select", 1'b1, low_current_select)
    // Unchanged low-current bit may be written while running
    dev(8'h1a, 8'h01, 1'b1, 8'h01);
    device_powered_down <= 1'b1;
    dev(8'h1a, 8'h00, 1'b1, 8'h01);
    `CHK("low_current_select", 1'b0, low_current_select)
    // Interrupt source: reload bit, sticky events cleared by reading
    boot_active <= 1'b1; diff_low_event <= 1'b1;
    @(posedge pclk);
    diff_low_event <= 1'b0;
    dev(8'h25, 8'h00, 1'b0, 8'h86);
    dev(8'h25, 8'h00, 1'b0, 8'h80);
    boot_active <= 1'b0; diff_high_event <= 1'b1;
    @(posedge pclk);
    diff_high_event <= 1'b0;
    dev(8'h25, 8'h00, 1'b0, 8'h05);
    // Queue status over empty, full and random fills
    for (int i = 0; i < 12; i++) begin
      queue_fill_level <= (i < 2) ? 6'(i * 32) : 6'({$random(seed)} % 33);
      watermark_level <= 5'($random(seed));
      queue_overrun_bit <= (i == 1) ? 1'b1 : 1'($random(seed));
      @(posedge pclk);
      dev(8'h26, 8'h00, 1'b0, {queue_fill_level >= {1'b0, watermark_level},
        queue_overrun_bit && queue_fill_level == 6'h20, queue_fill_level});
    end
    // Results: available, overrun, offset subtraction, snapshot and clear on read
    for (int i = 0; i < 4; i++) begin
      press_offset <= 16'($random(seed));
      stage(24'($random(seed)), 16'($random(seed)), 1'(i));
      dev(8'h27, 8'h00, 1'b0, 8'h03);
      p = 24'($random(seed));
      stage(p, 16'($random(seed)), 1'(i));
      dev(8'h27, 8'h00, 1'b0, 8'h33);
      e = p - {{8{press_offset[15]}}, press_offset};
      dev(8'h28, 8'h00, 1'b0, e[7:0]);
      t = 16'($random(seed));
      stage(24'($random(seed)), t, 1'(i));
      dev(8'h29, 8'h00, 1'b0, e[15:8]);
      dev(8'h2a, 8'h00, 1'b0, e[23:16]);
      dev(8'h2b, 8'h00, 1'b0, t[7:0]);
      dev(8'h2c, 8'h00, 1'b0, t[15:8]);
      dev(8'h27, 8'h00, 1'b0, 8'h00);
    end
    // Filter reset with the filter on and off; writes to read-only places ignored
    press_lowpass_filter <= 1'b1;
    dev(8'h33, 8'h00, 1'b0, 8'h00);
    press_lowpass_filter <= 1'b0;
    dev(8'h33, 8'h00, 1'b0, 8'h00);
    dev(8'h27, 8'hff, 1'b1, 8'h00);
    dev(8'h27, 8'h00, 1'b0, 8'h00);
    test_done;
  end
endmodule
